// *** chi_pkg.sv ***
// Constants and types for the charger host register interface.
// Assumes a 20 MHz system clock and an I2C master driving SCL.
package chi_pkg;

  // System clock rate
  localparam int CLK_HZ = 20_000_000;

  // Slave addresses
  localparam logic [6:0] ADDR_USB = 7'h6B;
  localparam logic [6:0] ADDR_AC = 7'h6A;

  // Register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] REG_VOLT = 8'h02;
  localparam logic [7:0] REG_LIMIT = 8'h06;

  // Reset values
  localparam logic RST_EN_STAT = 1'h1;
  localparam logic [7:0] RST_CTRL = 8'h30;
  localparam logic [7:0] RST_VOLT = 8'h0A;
  localparam logic [7:0] RST_LIMIT = 8'h40;

  // Field positions, status register
  localparam int B_RESTART = 7;
  localparam int B_EN_STAT = 6;
  // Field positions, control register
  localparam int B_LIMIT_LO = 6;
  localparam int B_WEAK_HI = 5;
  localparam int B_WEAK_LO = 4;
  localparam int B_CUTOFF = 3;
  localparam int B_CHG_OFF = 2;
  localparam int B_FLOAT = 1;
  localparam int B_BOOST = 0;
  // Field positions, voltage register
  localparam int B_VCODE_LO = 2;
  localparam int B_ROLE_POL = 1;
  localparam int B_ROLE_EN = 0;

  // Charge state and fault codes
  localparam logic [1:0] CS_CHARGING = 2'h1;
  localparam logic [1:0] CS_FAULT = 2'h3;
  localparam logic [2:0] FLT_NORMAL = 3'h0;
  localparam logic [2:0] FLT_TIMER = 3'h6;

  // Boost watchdog, seconds and cycles
  localparam int WD_TIME_S = 32;
  localparam int WD_CYCLES = WD_TIME_S * CLK_HZ;

  // Status pin pulse, microseconds and cycles (least time, rounded up)
  localparam int PULSE_TIME_US = 128;
  localparam int PULSE_CYCLES = int'((64'(PULSE_TIME_US) * 64'(CLK_HZ)
    + 64'd999_999) / 64'd1_000_000);

  // I2C engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } chi_i2c_e;

endpackage

// *** chi_sync3.sv ***
// Three-stage synchroniser with agreement filter.
// Assumes each bit is an independent level from another domain.
`timescale 1ns/1ps
`default_nettype none
module chi_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // Width check
  if (W < 1) begin : g_chk
    $error("chi_sync3: W must be at least 1");
  end

  // Output follows only where stages two and three agree
  assign q_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_reg);
  assign q_o = q_reg;

  // Stage chain
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

endmodule
`default_nettype wire

// *** chi_timer.sv ***
// Loadable down-counter used for the watchdog and the pin pulse.
// Assumes load and run come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module chi_timer #(
  parameter int W = 12,
  parameter int LOAD = 2560
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Control
  input wire logic run_i,
  input wire logic load_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  localparam logic [W-1:0] LOAD_W = W'(LOAD);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Count must fit the width
  if (W < 1 || W > 30 || LOAD < 1 || LOAD > (2 ** W) - 1) begin : g_chk
    $error("chi_timer: LOAD does not fit W");
  end

  // Stop clears, load restarts, else count down to zero
  assign cnt_next = !run_i ? '0 :
                    load_i ? LOAD_W :
                    (cnt_reg != '0) ? cnt_reg - W'(1) : '0;
  assign busy_o = cnt_reg != '0;
  assign done_o = run_i & ~load_i & (cnt_reg == W'(1));

  // Counter
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule
`default_nettype wire

// *** chi_regif.sv ***
// Host register interface of a dual-input charger: I2C slave on SCL,
// status, control and voltage registers, boost watchdog, status pin,
// safety-limit lock.
// Assumes analog status arrives as pin levels and the master owns SCL.
`timescale 1ns/1ps
`default_nettype none
module chi_regif
  import chi_pkg::*;
#(
  parameter int WD_CYCLES_P = WD_CYCLES
) (
  // System clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // I2C link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Status pin, open drain
  input wire logic stat_i,
  output logic stat_o,
  output logic stat_oe_o,
  // Pins and analog status
  input wire logic host_role_pin_i,
  input wire logic limit_lock_reset_pin_i,
  input wire logic vin_present_i,
  input wire logic vbus_present_i,
  input wire logic [1:0] charge_state_i,
  input wire logic [2:0] fault_code_i,
  // Control outputs
  output logic [1:0] input_limit_sel_o,
  output logic weak_batt_thresh_hi_o,
  output logic weak_batt_thresh_lo_o,
  output logic end_cutoff_on_o,
  output logic charge_disable_o,
  output logic input_float_sel_o,
  output logic boost_run_o,
  output logic timer_fault_o,
  output logic [5:0] regulation_voltage_code_o,
  output logic role_pin_polarity_o,
  output logic role_pin_enable_o,
  output logic [7:0] safety_limit_o
);

  localparam int WD_W = $clog2(WD_CYCLES_P + 1);
  localparam int PULSE_W = $clog2(PULSE_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  // Link side
  logic start_tgl_reg;
  logic start_ack_reg;
  chi_i2c_e state_reg;
  logic [3:0] bcnt_reg;
  logic [7:0] shreg_reg;
  logic [7:0] ptr_reg;
  logic [7:0] tx_reg;
  logic usb_reg;
  logic wr_tgl_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic sda_oe_reg;
  logic sda_o_reg;
  logic [31:0] img_s;
  logic new_start;
  logic ack_slot;
  logic [6:0] dev;
  logic dev_usb;
  logic addr_hit;
  logic ack_drive;
  logic bit_drive;
  logic [7:0] ptr_inc;

  // System side
  logic [8:0] pin_s;
  logic role_s;
  logic lock_pin_s;
  logic vin_s;
  logic vbus_s;
  logic [1:0] cs_s;
  logic [2:0] fc_s;
  logic wr_tgl_s;
  logic wr_seen_reg;
  logic wr_evt;
  logic wr_st;
  logic wr_ctrl;
  logic wr_volt;
  logic wr_lim;
  logic restart;
  logic lim_ok;
  logic lock_set;
  logic en_stat_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] volt_reg;
  logic [7:0] lim_reg;
  logic lock_reg;
  logic wd_fault_reg;
  logic boost_prev_reg;
  logic boost_run_reg;
  logic [2:0] code_prev_reg;
  logic vin_prev_reg;
  logic vbus_prev_reg;
  logic stat_oe_reg;
  logic stat_o_reg;
  logic [31:0] img_reg;
  logic boost_on;
  logic boost_rise;
  logic wd_load;
  logic wd_done;
  logic fault_clr;
  logic [2:0] code_now;
  logic [1:0] cs_now;
  logic flt_pulse;
  logic pres_chg;
  logic pulse_load;
  logic pulse_busy;
  logic stat_oe_next;

  // Read byte for a register offset from the image
  function automatic logic [7:0] rd_sel(input logic [7:0] a,
                                        input logic [31:0] img);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      REG_STATUS: r = img[7:0];
      REG_CTRL: r = img[15:8];
      REG_VOLT: r = img[23:16];
      REG_LIMIT: r = img[31:24];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Link domain: start capture
  // SDA falling while SCL high flags a start or repeated start. The
  // toggle is read on the next SCL rise, which the bus timing keeps
  // well after it; a synchroniser would swallow the first address bit.
  always_ff @(negedge sda_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_tgl_reg <= 1'h0;
    end else if (scl_i) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  // Register image carried into the link domain
  chi_sync3 #(.W(32)) u_img_sync (
    .clock_i(scl_i),
    .rst_b_i(rst_b_i),
    .d_i(img_reg),
    .q_o(img_s)
  );

  // Byte decode
  assign new_start = start_tgl_reg ^ start_ack_reg;
  assign ack_slot = bcnt_reg == 4'h8;
  assign dev = shreg_reg[7:1];
  assign dev_usb = dev == ADDR_USB;
  assign addr_hit = dev_usb || dev == ADDR_AC;
  assign ptr_inc = ptr_reg + 8'h01;

  // SDA drive: acknowledge slots and zero bits of read data
  assign ack_drive = ack_slot & ((state_reg == ST_ADDR & addr_hit) |
                                 state_reg == ST_PTR |
                                 state_reg == ST_WDATA);
  assign bit_drive = state_reg == ST_RDATA & ~ack_slot & ~tx_reg[7];

  // Sample side of the engine, on SCL rise
  always_ff @(posedge scl_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_ack_reg <= 1'h0;
      state_reg <= ST_IDLE;
      bcnt_reg <= 4'h0;
      shreg_reg <= 8'h00;
      ptr_reg <= 8'h00;
      tx_reg <= 8'h00;
      usb_reg <= 1'h0;
      wr_tgl_reg <= 1'h0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else if (new_start) begin
      start_ack_reg <= start_tgl_reg;
      state_reg <= ST_ADDR;
      bcnt_reg <= 4'h1;
      shreg_reg <= {7'h00, sda_i};
    end else if (!ack_slot) begin
      if (state_reg != ST_IDLE) begin
        shreg_reg <= {shreg_reg[6:0], sda_i};
        bcnt_reg <= bcnt_reg + 4'h1;
        tx_reg <= {tx_reg[6:0], 1'h0};
      end
    end else begin
      bcnt_reg <= 4'h0;
      case (state_reg)
        ST_ADDR: begin
          // A high-speed master code matches no address and is left
          // unacknowledged; the repeated start that follows restarts
          if (!addr_hit) begin
            state_reg <= ST_IDLE;
          end else if (shreg_reg[0]) begin
            usb_reg <= dev_usb;
            state_reg <= ST_RDATA;
            tx_reg <= dev_usb ? rd_sel(ptr_reg, img_s) : 8'h00;
          end else begin
            usb_reg <= dev_usb;
            state_reg <= ST_PTR;
          end
        end
        ST_PTR: begin
          ptr_reg <= shreg_reg;
          state_reg <= ST_WDATA;
        end
        ST_WDATA: begin
          if (usb_reg) begin
            wr_addr_reg <= ptr_reg;
            wr_data_reg <= shreg_reg;
            wr_tgl_reg <= ~wr_tgl_reg;
          end
          ptr_reg <= ptr_inc;
        end
        ST_RDATA: begin
          // Master NACK ends the read
          if (sda_i) begin
            state_reg <= ST_IDLE;
          end else begin
            ptr_reg <= ptr_inc;
            tx_reg <= usb_reg ? rd_sel(ptr_inc, img_s) : 8'h00;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Drive side of the engine, on SCL fall; released across a start
  always_ff @(negedge scl_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_oe_reg <= 1'h0;
      sda_o_reg <= 1'h0;
    end else begin
      sda_oe_reg <= ~new_start & (ack_drive | bit_drive);
      sda_o_reg <= 1'h0;
    end
  end

  assign sda_oe_o = sda_oe_reg;
  assign sda_o = sda_o_reg;

  //////////////////////////////////////////////////////////////////////////
  // System domain: input synchronisers

  // Pin levels
  chi_sync3 #(.W(9)) u_pin_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i({host_role_pin_i, limit_lock_reset_pin_i, vin_present_i,
          vbus_present_i, charge_state_i, fault_code_i}),
    .q_o(pin_s)
  );

  assign role_s = pin_s[8];
  assign lock_pin_s = pin_s[7];
  assign vin_s = pin_s[6];
  assign vbus_s = pin_s[5];
  assign cs_s = pin_s[4:3];
  assign fc_s = pin_s[2:0];

  // Write event toggle; address and data stand still until the next
  // byte, far longer than the crossing takes
  chi_sync3 #(.W(1)) u_wr_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i(wr_tgl_reg),
    .q_o(wr_tgl_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_evt = wr_tgl_s ^ wr_seen_reg;
  assign wr_st = wr_evt & (wr_addr_reg == REG_STATUS);
  assign wr_ctrl = wr_evt & (wr_addr_reg == REG_CTRL);
  assign wr_volt = wr_evt & (wr_addr_reg == REG_VOLT);
  assign wr_lim = wr_evt & (wr_addr_reg == REG_LIMIT);
  assign restart = wr_st & wr_data_reg[B_RESTART];
  assign lim_ok = wr_lim & lock_pin_s & ~lock_reg;
  assign lock_set = wr_evt & ~wr_lim & lock_pin_s;

  // Boost watchdog control
  assign boost_on = ctrl_reg[B_BOOST] & ~wd_fault_reg;
  assign boost_rise = boost_on & ~boost_prev_reg;
  assign wd_load = boost_rise | (restart & boost_on);
  assign fault_clr = restart | (wr_ctrl & ~wr_data_reg[B_BOOST]);

  // Reported state and codes
  assign code_now = wd_fault_reg ? FLT_TIMER : fc_s;
  assign cs_now = wd_fault_reg ? CS_FAULT : cs_s;

  // Status pin events
  assign flt_pulse = (code_now != FLT_NORMAL) &
                     (code_prev_reg == FLT_NORMAL) &
                     ~ctrl_reg[B_FLOAT];
  assign pres_chg = (vin_s ^ vin_prev_reg) | (vbus_s ^ vbus_prev_reg);
  assign pulse_load = flt_pulse | pres_chg;
  assign stat_oe_next = pulse_busy |
                        (en_stat_reg & (cs_now == CS_CHARGING));

  //////////////////////////////////////////////////////////////////////////
  // Timers

  // 32 s boost watchdog, cleared whenever boost is off
  chi_timer #(.W(WD_W), .LOAD(WD_CYCLES_P)) u_wd (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .run_i(boost_on),
    .load_i(wd_load),
    .busy_o(),
    .done_o(wd_done)
  );

  // 128 us status pin pulse, retriggerable
  chi_timer #(.W(PULSE_W), .LOAD(PULSE_CYCLES)) u_pulse (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .run_i(1'h1),
    .load_i(pulse_load),
    .busy_o(pulse_busy),
    .done_o()
  );

  //////////////////////////////////////////////////////////////////////////
  // Host registers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_seen_reg <= 1'h0;
      en_stat_reg <= RST_EN_STAT;
      ctrl_reg <= RST_CTRL;
      volt_reg <= RST_VOLT;
    end else begin
      wr_seen_reg <= wr_tgl_s;
      if (wr_st) begin
        en_stat_reg <= wr_data_reg[B_EN_STAT];
      end
      if (wr_ctrl) begin
        ctrl_reg <= wr_data_reg;
      end
      if (wr_volt) begin
        volt_reg <= wr_data_reg;
      end
    end
  end

  // Safety limit and its lock
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lim_reg <= RST_LIMIT;
      lock_reg <= 1'h0;
    end else if (!lock_pin_s) begin
      lim_reg <= RST_LIMIT;
      lock_reg <= 1'h0;
    end else begin
      if (lim_ok) begin
        lim_reg <= wr_data_reg;
      end
      if (lock_set) begin
        lock_reg <= 1'h1;
      end
    end
  end

  // Watchdog fault; expiry wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_fault_reg <= 1'h0;
    end else if (wd_done) begin
      wd_fault_reg <= 1'h1;
    end else if (fault_clr) begin
      wd_fault_reg <= 1'h0;
    end
  end

  // Edge history and pin outputs
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boost_prev_reg <= 1'h0;
      boost_run_reg <= 1'h0;
      code_prev_reg <= FLT_NORMAL;
      vin_prev_reg <= 1'h0;
      vbus_prev_reg <= 1'h0;
      stat_oe_reg <= 1'h0;
      stat_o_reg <= 1'h0;
    end else begin
      boost_prev_reg <= boost_on;
      boost_run_reg <= boost_on;
      code_prev_reg <= code_now;
      vin_prev_reg <= vin_s;
      vbus_prev_reg <= vbus_s;
      stat_oe_reg <= stat_oe_next;
      stat_o_reg <= 1'h0;
    end
  end

  // Read image; bit 7 of the status register shows the role pin
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      img_reg <= 32'h0000_0000;
    end else begin
      img_reg <= {lim_reg, volt_reg, ctrl_reg,
                  role_s, en_stat_reg, cs_now, boost_on, code_now};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign stat_oe_o = stat_oe_reg;
  assign stat_o = stat_o_reg;
  assign input_limit_sel_o = ctrl_reg[7:B_LIMIT_LO];
  assign weak_batt_thresh_hi_o = ctrl_reg[B_WEAK_HI];
  assign weak_batt_thresh_lo_o = ctrl_reg[B_WEAK_LO];
  assign end_cutoff_on_o = ctrl_reg[B_CUTOFF];
  assign charge_disable_o = ctrl_reg[B_CHG_OFF];
  assign input_float_sel_o = ctrl_reg[B_FLOAT];
  assign boost_run_o = boost_run_reg;
  assign timer_fault_o = wd_fault_reg;
  assign regulation_voltage_code_o = volt_reg[7:B_VCODE_LO];
  assign role_pin_polarity_o = volt_reg[B_ROLE_POL];
  assign role_pin_enable_o = volt_reg[B_ROLE_EN];
  assign safety_limit_o = lim_reg;

endmodule
`default_nettype wire

// *** chi_regif_properties.sv ***
// Port checker for the charger register interface.
// Assumes it is bound into chi_regif and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module chi_regif_properties #(
  parameter int WD_CYCLES_P = 2000
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Watched ports
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic stat_o,
  input wire logic stat_oe_o,
  input wire logic limit_lock_reset_pin_i,
  input wire logic [1:0] input_limit_sel_o,
  input wire logic end_cutoff_on_o,
  input wire logic charge_disable_o,
  input wire logic input_float_sel_o,
  input wire logic boost_run_o,
  input wire logic timer_fault_o,
  input wire logic [5:0] regulation_voltage_code_o,
  input wire logic [7:0] safety_limit_o
);
  logic [15:0] hi_cnt;
  logic [31:0] run_cnt;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Length of the current pin-low and boost stretches
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_cnt <= 16'h0;
      run_cnt <= 32'h0;
    end else begin
      hi_cnt <= stat_oe_o ? hi_cnt + 16'h1 : 16'h0;
      run_cnt <= boost_run_o ? run_cnt + 32'h1 : 32'h0;
    end
  end
  a_fault_stops_boost: assert property (
    timer_fault_o |=> !boost_run_o) else $error("boost under timer fault");
  a_watchdog_min: assert property (
    $rose(timer_fault_o) |-> run_cnt + 32'h2 >= WD_CYCLES_P)
    else $error("watchdog expired early");
  a_boost_clean: assert property (
    $rose(boost_run_o) |-> !$past(timer_fault_o))
    else $error("boost started under fault");
  a_pulse_length: assert property (
    $fell(stat_oe_o) |-> hi_cnt >= 16'hA00) else $error("short stat pulse");
  a_lock_default: assert property (
    !limit_lock_reset_pin_i [*6] |-> safety_limit_o == 8'h40)
    else $error("limit not held at default");
  a_idle_sda_free: assert property (
    scl_i [*8] |-> !sda_oe_o) else $error("sda held while bus idle");
  a_ctrl_idle_hold: assert property (
    scl_i [*8] |=> $stable(input_limit_sel_o) && $stable(end_cutoff_on_o)
      && $stable(charge_disable_o) && $stable(input_float_sel_o)
      && $stable(regulation_voltage_code_o))
    else $error("control changed without bus traffic");
  a_open_drain: assert property (
    !sda_o && !stat_o) else $error("open drain pin driven high");
endmodule
bind chi_regif chi_regif_properties #(.WD_CYCLES_P(WD_CYCLES_P)) i_chk (
  .clock_i, .rst_b_i, .scl_i, .sda_o, .sda_oe_o, .stat_o, .stat_oe_o,
  .limit_lock_reset_pin_i, .input_limit_sel_o, .end_cutoff_on_o,
  .charge_disable_o, .input_float_sel_o, .boost_run_o, .timer_fault_o,
  .regulation_voltage_code_o, .safety_limit_o);
`default_nettype wire

// *** chi_i2c_host.sv ***
// I2C host model for the charger register interface.
// Assumes SDA is resolved outside with a pull-up; SCL idles high.
`timescale 1ns/1ps
`default_nettype none
module chi_i2c_host (
  // Bus lines
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // Bus idle at time zero
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Start or repeated start
  task automatic start();
    sda_low_o = 1'b0;
    #1.5 scl_o = 1'b1;
    #1.5 sda_low_o = 1'b1;
    #1.5 scl_o = 1'b0;
    #1.5;
  endtask
  // One bit, SDA moves only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = !b;
    #1.5 scl_o = 1'b1;
    r = sda_i;
    #3 scl_o = 1'b0;
    #1.5;
  endtask
  // Byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic m,
      output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q[i] = b;
    end
    bit_io(m, b);
    ack = !b;
  endtask
  // Stop, SDA rises while SCL high
  task automatic stop();
    sda_low_o = 1'b1;
    #1.5 scl_o = 1'b1;
    #1.5 sda_low_o = 1'b0;
    #3;
  endtask
  // Address, pointer, data
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, d,
      output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({a, 1'b0}, 1'b1, q, k0);
    xfer(p, 1'b1, q, k1);
    xfer(d, 1'b1, q, k2);
    stop();
    ok = k0 && k1 && k2;
  endtask
  // Address, pointer, repeated start, one byte then not-acknowledge
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p,
      output logic [7:0] d, output logic ok);
    logic k0, k1, k2, k3;
    start();
    xfer({a, 1'b0}, 1'b1, d, k0);
    xfer(p, 1'b1, d, k1);
    start();
    xfer({a, 1'b1}, 1'b1, d, k2);
    xfer(8'hFF, 1'b1, d, k3);
    stop();
    ok = k0 && k1 && k2;
  endtask
endmodule
`default_nettype wire

// *** test_charger_host_register_interface.sv ***
// Testbench for the charger host register interface.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_charger_host_register_interface
  import chi_pkg::*;
;
  logic clock_i, rst_b_i, scl, sda_low, sda_w, sda_oe, sda_out, ok;
  logic stat_w, stat_out, stat_oe, role, lock, vin, vbus, r;
  logic wh, wl, cut, chg_off, flt_sel, boost, tfault, pol, ren;
  logic [1:0] cs, lim, s;
  logic [2:0] flt;
  logic [5:0] vcode;
  logic [7:0] slim, rd, d, v, ctl;
  int n_fail = 0;
  int compares = 0;
  int seed = 32'h95AC;
  // Clock and open-drain wires
  always #25 clock_i = ~clock_i;
  assign sda_w = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  assign stat_w = stat_oe ? stat_out : 1'b1;
  // Control outputs gathered in register bit order
  assign ctl = {lim, wh, wl, cut, chg_off, flt_sel, boost};
  chi_regif #(.WD_CYCLES_P(2000)) i_chi_regif (
    .clock_i, .rst_b_i, .scl_i(scl), .sda_i(sda_w), .sda_o(sda_out),
    .sda_oe_o(sda_oe), .stat_i(stat_w), .stat_o(stat_out),
    .stat_oe_o(stat_oe), .host_role_pin_i(role),
    .limit_lock_reset_pin_i(lock), .vin_present_i(vin),
    .vbus_present_i(vbus), .charge_state_i(cs), .fault_code_i(flt),
    .input_limit_sel_o(lim), .weak_batt_thresh_hi_o(wh),
    .weak_batt_thresh_lo_o(wl), .end_cutoff_on_o(cut),
    .charge_disable_o(chg_off), .input_float_sel_o(flt_sel),
    .boost_run_o(boost), .timer_fault_o(tfault),
    .regulation_voltage_code_o(vcode), .role_pin_polarity_o(pol),
    .role_pin_enable_o(ren), .safety_limit_o(slim));
  chi_i2c_host i_chi_i2c_host (.scl_o(scl), .sda_low_o(sda_low),
    .sda_i(sda_w));
  // Expected status register image
  function automatic logic [7:0] st_exp(input logic rp, t,
      input logic [1:0] c, input logic [2:0] f);
    return t ? {rp, 1'b1, CS_FAULT, 1'b0, FLT_TIMER} : {rp, 1'b1, c, 1'b0, f};
  endfunction
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, g);
    chk8(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic wclk(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, dv);
    i_chi_i2c_host.write_reg(a, p, dv, ok);
    chk1("ack", a == ADDR_USB || a == ADDR_AC, ok);
    wclk(10);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] p, e);
    i_chi_i2c_host.read_reg(a, p, rd, ok);
    chk8("readback", e, rd);
    wclk(4);
  endtask
  task automatic drv(input logic [1:0] c, input logic [2:0] f);
    @(posedge clock_i);
    cs <= c;
    flt <= f;
    wclk(8);
  endtask
  task automatic pulse_chk();
    wclk(8);
    chk1("stat", 1'b1, stat_oe);
    wclk(2530);
    chk1("stat", 1'b1, stat_oe);
    wclk(60);
    chk1("stat", 1'b0, stat_oe);
  endtask
  // Main sequence
  initial begin
    clock_i = 1'b0;
    rst_b_i = 1'b0;
    {role, lock, vin, vbus, cs, flt} = 9'h080;
    wclk(20);
    rst_b_i <= 1'b1;
    wclk(6);
    chk8("ctrl", RST_CTRL, ctl);
    chk8("volt", RST_VOLT, {vcode, pol, ren});
    v = st_exp(1'b0, 1'b0, 2'h0, 3'h0);
    rdchk(ADDR_USB, REG_STATUS, v);
    rdchk(ADDR_USB, REG_CTRL, RST_CTRL);
    rdchk(ADDR_USB, REG_VOLT, RST_VOLT);
    d = 8'($random(seed));
    wr(ADDR_USB, REG_LIMIT, d);
    chk8("limit", d, slim);
    wr(ADDR_USB, REG_CTRL, RST_CTRL);
    wr(ADDR_USB, REG_LIMIT, ~d);
    chk8("limit", d, slim);
    lock <= 1'b0;
    wclk(8);
    wr(ADDR_USB, REG_LIMIT, ~d);
    chk8("limit", RST_LIMIT, slim);
    lock <= 1'b1;
    wclk(8);
    wr(ADDR_USB, REG_LIMIT, ~d);
    rdchk(ADDR_USB, REG_LIMIT, ~d);
    for (int k = 0; k < 6; k++) begin
      d = k == 0 ? 8'hFE : 8'($random(seed)) & 8'hFE;
      v = k == 1 ? 8'h00 : 8'($random(seed));
      wr(ADDR_USB, REG_CTRL, d);
      wr(ADDR_USB, REG_VOLT, v);
      chk8("ctrl", d, ctl);
      chk8("volt", v, {vcode, pol, ren});
      rdchk(ADDR_USB, REG_CTRL, d);
      rdchk(ADDR_USB, REG_VOLT, v);
    end
    wr(ADDR_AC, REG_CTRL, 8'hFF);
    wr(7'h55, REG_CTRL, 8'hFF);
    rdchk(ADDR_USB, REG_CTRL, d);
    rdchk(ADDR_AC, REG_CTRL, 8'h00);
    rdchk(ADDR_USB, 8'h05, 8'h00);
    wr(ADDR_USB, REG_CTRL, 8'h32);
    for (int c = 0; c < 8; c++) begin
      r = 1'($random(seed));
      s = c[1:0] == 2'h1 ? 2'h2 : c[1:0];
      role <= r;
      drv(s, 3'(c));
      v = st_exp(r, 1'b0, s, 3'(c));
      rdchk(ADDR_USB, REG_STATUS, v);
      chk1("stat", 1'b0, stat_oe);
    end
    drv(2'h0, 3'h0);
    wr(ADDR_USB, REG_CTRL, 8'h30);
    drv(2'h0, 3'h5);
    pulse_chk();
    drv(2'h0, 3'h0);
    wr(ADDR_USB, REG_CTRL, 8'h32);
    vin <= 1'b1;
    pulse_chk();
    vbus <= 1'b1;
    pulse_chk();
    vin <= 1'b0;
    pulse_chk();
    drv(CS_CHARGING, 3'h0);
    wclk(2600);
    chk1("stat", 1'b1, stat_oe);
    rdchk(ADDR_USB, REG_STATUS, st_exp(r, 1'b0, CS_CHARGING, 3'h0));
    wr(ADDR_USB, REG_STATUS, 8'h00);
    chk1("stat", 1'b0, stat_oe);
    drv(2'h0, 3'h0);
    wr(ADDR_USB, REG_STATUS, 8'h40);
    wr(ADDR_USB, REG_CTRL, 8'h31);
    chk1("boost", 1'b1, boost);
    wclk(1500);
    wr(ADDR_USB, REG_STATUS, 8'hC0);
    wclk(1500);
    chk1("boost", 1'b1, boost);
    for (int i = 0; i < 2600 && tfault !== 1'b1; i++) begin
      wclk(1);
    end
    chk1("timer fault", 1'b1, tfault);
    if (tfault === 1'b1) begin
      wclk(2);
      chk1("boost", 1'b0, boost);
      chk1("stat", 1'b1, stat_oe);
      v = st_exp(r, 1'b1, 2'h0, 3'h0);
      rdchk(ADDR_USB, REG_STATUS, v);
      wr(ADDR_USB, REG_CTRL, 8'h30);
      chk1("timer fault", 1'b0, tfault);
      wclk(2700);
    end
    finish_test();
  end
endmodule
`default_nettype wire
